// *** core/cfsp_pkg.sv ***
// Shared constants and types for the CPU flag register and stack pointer.
// Assumes one 50 MHz clock and a partner sequencer on that same clock.
package cfsp_pkg;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [7:0] SP_HIGH = 8'h01;
    localparam logic [7:0] SP_TOP = 8'hff;
    localparam logic [15:0] SP_RESET = 16'h01ff;
    localparam int BIT_H = 4;
    localparam int BIT_I = 3;
    localparam int BIT_N = 2;
    localparam int BIT_Z = 1;
    localparam int BIT_C = 0;
    localparam int BIT_SIGN = 7;
    localparam logic [7:0] FLAG_FIXED = 8'he0;
    localparam logic [7:0] FLAG_RESET = 8'he8;
    localparam logic [2:0] ONE_BYTE = 3'h1;
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] INT_BYTES = 3'h5;
    localparam int CTX_W = 40;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_MASK_SET = 4'h1, CMD_UNMASK = 4'h2,
        CMD_CARRY_SET = 4'h3, CMD_CARRY_CLR = 4'h4, CMD_SP_RELOAD = 4'h5,
        CMD_SP_LOAD = 4'h6, CMD_PUSH = 4'h7, CMD_POP = 4'h8,
        CMD_PUSH_FLAGS = 4'h9, CMD_POP_FLAGS = 4'ha, CMD_CALL = 4'hb,
        CMD_RET = 4'hc, CMD_INT_ENTRY = 4'hd, CMD_RETURN_FROM_HANDLER = 4'he, CMD_TRAP = 4'hf
    } cfsp_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_PUSH = 2'b01, ST_POPA = 2'b10, ST_POPD = 2'b11
    } cfsp_state_t;

    typedef struct packed {
        cfsp_cmd_t cmd;
        logic [7:0] data;
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] acc;
    } cfsp_req_t;

    typedef struct packed {
        logic valid;
        logic isAdd;
        logic updC;
        logic [7:0] opA;
        logic [7:0] opB;
        logic [7:0] result;
        logic carry;
    } cfsp_alu_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] acc;
    } cfsp_ctx_t;

endpackage

// *** core/cfsp_stack_ram.sv ***
// Stack memory with one write port and a registered read port.
// Assumes the owner never needs the written byte back in the same cycle.
`timescale 1ns/1ps
module cfsp_stack_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData_ff
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= mem[rdAddr];
        end
    end

endmodule

// *** core/cfsp_flags_stack.sv ***
// Flag register, stack pointer, stack sequencer and pending interrupt latch.
// Assumes the execution unit issues one request at a time while busy_ff is low.
`timescale 1ns/1ps
module cfsp_flags_stack #(
    parameter int IRQ_NUM = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reqValid,
    input wire cfsp_pkg::cfsp_req_t req,
    input wire cfsp_pkg::cfsp_alu_t alu,
    input wire logic [IRQ_NUM-1:0] irqReq,
    output logic busy_ff,
    output logic done_ff,
    output logic [7:0] flags_ff,
    output logic [15:0] sp_ff,
    output logic [7:0] popData_ff,
    output cfsp_pkg::cfsp_ctx_t ctx_ff,
    output logic irqTake_ff,
    output logic [((IRQ_NUM > 1) ? $clog2(IRQ_NUM) : 1)-1:0] irqId_ff
);

    localparam int IDW = (IRQ_NUM > 1) ? $clog2(IRQ_NUM) : 1;

    if (IRQ_NUM < 1 || IRQ_NUM > 8) begin : g_bad_irq_num
        $error("IRQ_NUM must lie between 1 and 8");
    end

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    cfsp_pkg::cfsp_state_t state_ff, nxt_state;
    cfsp_pkg::cfsp_cmd_t kind_ff;
    logic [2:0] cnt_ff;
    logic [cfsp_pkg::CTX_W-1:0] pushSh_ff, popSh_ff, popNew;
    logic [IRQ_NUM-1:0] pend_ff;
    logic [7:0] ramRd, rdAddr, halfX;
    logic acc, lastPush, lastPop, restore, entry, aluOnly;
    logic [IDW-1:0] topId;
    logic anyPend;

    function automatic logic [2:0] byteCount(input cfsp_pkg::cfsp_cmd_t c);
        unique case (c)
            cfsp_pkg::CMD_PUSH, cfsp_pkg::CMD_POP,
            cfsp_pkg::CMD_PUSH_FLAGS, cfsp_pkg::CMD_POP_FLAGS: byteCount = cfsp_pkg::ONE_BYTE;
            cfsp_pkg::CMD_CALL, cfsp_pkg::CMD_RET: byteCount = cfsp_pkg::CALL_BYTES;
            cfsp_pkg::CMD_INT_ENTRY, cfsp_pkg::CMD_TRAP,
            cfsp_pkg::CMD_RETURN_FROM_HANDLER: byteCount = cfsp_pkg::INT_BYTES;
            default: byteCount = 3'h0;
        endcase
    endfunction

    function automatic logic isPop(input cfsp_pkg::cfsp_cmd_t c);
        isPop = (c == cfsp_pkg::CMD_POP) || (c == cfsp_pkg::CMD_POP_FLAGS)
            || (c == cfsp_pkg::CMD_RET) || (c == cfsp_pkg::CMD_RETURN_FROM_HANDLER);
    endfunction

    assign acc = reqValid && !busy_ff;
    assign entry = acc && (req.cmd == cfsp_pkg::CMD_INT_ENTRY || req.cmd == cfsp_pkg::CMD_TRAP);
    assign popNew = {popSh_ff[cfsp_pkg::CTX_W-9:0], ramRd};
    assign lastPush = (state_ff == cfsp_pkg::ST_PUSH) && (cnt_ff == cfsp_pkg::ONE_BYTE);
    assign lastPop = (state_ff == cfsp_pkg::ST_POPD) && (cnt_ff == cfsp_pkg::ONE_BYTE);
    assign restore = lastPop && (kind_ff == cfsp_pkg::CMD_POP_FLAGS || kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER);
    assign aluOnly = alu.valid && !restore;
    assign rdAddr = sp_ff[7:0] + 8'h01;
    assign halfX = alu.opA ^ alu.opB ^ alu.result;

    // ----------------------------------------------------------------
    // Stack sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cfsp_pkg::ST_IDLE: begin
                if (acc && byteCount(req.cmd) != 3'h0) begin
                    nxt_state = isPop(req.cmd) ? cfsp_pkg::ST_POPA : cfsp_pkg::ST_PUSH;
                end
            end
            cfsp_pkg::ST_PUSH: begin
                if (lastPush) begin
                    nxt_state = cfsp_pkg::ST_IDLE;
                end
            end
            cfsp_pkg::ST_POPA: begin
                nxt_state = cfsp_pkg::ST_POPD;
            end
            cfsp_pkg::ST_POPD: begin
                nxt_state = lastPop ? cfsp_pkg::ST_IDLE : cfsp_pkg::ST_POPA;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= cfsp_pkg::ST_IDLE;
            busy_ff <= 1'b0;
            cnt_ff <= 3'h0;
            kind_ff <= cfsp_pkg::CMD_NOP;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != cfsp_pkg::ST_IDLE);
            if (state_ff == cfsp_pkg::ST_IDLE && acc) begin
                cnt_ff <= byteCount(req.cmd);
                kind_ff <= req.cmd;
            end else if (state_ff == cfsp_pkg::ST_PUSH || state_ff == cfsp_pkg::ST_POPD) begin
                cnt_ff <= cnt_ff - 3'h1;
            end
        end
    end

    // Push bytes leave from the low end; the context byte order is RETURN_ADDRESS_LOW, PCH, X, A, flags.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pushSh_ff <= '0;
        end else if (acc) begin
            unique case (req.cmd)
                cfsp_pkg::CMD_INT_ENTRY, cfsp_pkg::CMD_TRAP: begin
                    pushSh_ff <= {flags_ff, req.acc, req.x, req.pc};
                end
                cfsp_pkg::CMD_CALL: pushSh_ff <= {24'h0, req.pc};
                cfsp_pkg::CMD_PUSH: pushSh_ff <= {32'h0, req.data};
                cfsp_pkg::CMD_PUSH_FLAGS: pushSh_ff <= {32'h0, flags_ff};
                default: pushSh_ff <= pushSh_ff;
            endcase
        end else if (state_ff == cfsp_pkg::ST_PUSH) begin
            pushSh_ff <= {8'h00, pushSh_ff[cfsp_pkg::CTX_W-1:8]};
        end
    end

    // Popped bytes enter at the low end, so the layout mirrors the push layout.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            popSh_ff <= '0;
        end else if (acc) begin
            popSh_ff <= '0;
        end else if (state_ff == cfsp_pkg::ST_POPD) begin
            popSh_ff <= popNew;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_ff <= 1'b0;
            popData_ff <= 8'h00;
            ctx_ff <= '0;
        end else begin
            done_ff <= lastPush || lastPop;
            if (lastPop) begin
                popData_ff <= ramRd;
                if (kind_ff == cfsp_pkg::CMD_RET) begin
                    ctx_ff.pc <= popNew[15:0];
                end else if (kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER) begin
                    ctx_ff <= {popNew[15:0], popNew[23:16], popNew[31:24]};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Stack pointer
    // ----------------------------------------------------------------
    // Only the low byte moves; eight-bit arithmetic gives the silent wrap.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_ff <= cfsp_pkg::SP_RESET;
        end else if (acc && req.cmd == cfsp_pkg::CMD_SP_RELOAD) begin
            sp_ff <= {cfsp_pkg::SP_HIGH, cfsp_pkg::SP_TOP};
        end else if (acc && req.cmd == cfsp_pkg::CMD_SP_LOAD) begin
            sp_ff <= {cfsp_pkg::SP_HIGH, req.data};
        end else if (state_ff == cfsp_pkg::ST_PUSH) begin
            sp_ff <= {cfsp_pkg::SP_HIGH, sp_ff[7:0] - 8'h01};
        end else if (state_ff == cfsp_pkg::ST_POPA) begin
            sp_ff <= {cfsp_pkg::SP_HIGH, rdAddr};
        end
    end

    cfsp_stack_ram #(
        .AW(8),
        .DW(8)
    ) u_ram (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(state_ff == cfsp_pkg::ST_PUSH),
        .wrAddr(sp_ff[7:0]),
        .wrData(pushSh_ff[7:0]),
        .rdAddr(rdAddr),
        .rdData_ff(ramRd)
    );

    // ----------------------------------------------------------------
    // Flag register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= cfsp_pkg::FLAG_RESET;
        end else if (restore) begin
            flags_ff <= popNew[7:0] | cfsp_pkg::FLAG_FIXED;
            if (kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER) begin
                flags_ff <= {popNew[39:36] | cfsp_pkg::FLAG_FIXED[7:4], 1'b0, popNew[34:32]};
            end
        end else begin
            if (alu.valid) begin
                flags_ff[cfsp_pkg::BIT_N] <= alu.result[cfsp_pkg::BIT_SIGN];
                flags_ff[cfsp_pkg::BIT_Z] <= (alu.result == 8'h00);
                if (alu.isAdd) begin
                    flags_ff[cfsp_pkg::BIT_H] <= halfX[cfsp_pkg::BIT_H];
                end
                if (alu.isAdd || alu.updC) begin
                    flags_ff[cfsp_pkg::BIT_C] <= alu.carry;
                end
            end
            if (acc) begin
                unique case (req.cmd)
                    cfsp_pkg::CMD_MASK_SET, cfsp_pkg::CMD_INT_ENTRY,
                    cfsp_pkg::CMD_TRAP: flags_ff[cfsp_pkg::BIT_I] <= 1'b1;
                    cfsp_pkg::CMD_UNMASK: flags_ff[cfsp_pkg::BIT_I] <= 1'b0;
                    cfsp_pkg::CMD_CARRY_SET: flags_ff[cfsp_pkg::BIT_C] <= 1'b1;
                    cfsp_pkg::CMD_CARRY_CLR: flags_ff[cfsp_pkg::BIT_C] <= 1'b0;
                    default: flags_ff[cfsp_pkg::BIT_I] <= flags_ff[cfsp_pkg::BIT_I];
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Pending interrupts
    // ----------------------------------------------------------------
    // A new request in the cycle of its own entry clear is kept.
    for (genvar i = 0; i < IRQ_NUM; i++) begin : g_pend
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                pend_ff[i] <= 1'b0;
            end else if (irqReq[i]) begin
                pend_ff[i] <= 1'b1;
            end else if (acc && req.cmd == cfsp_pkg::CMD_INT_ENTRY && req.data[IDW-1:0] == IDW'(i)) begin
                pend_ff[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        topId = '0;
        anyPend = |pend_ff;
        for (int k = IRQ_NUM - 1; k >= 0; k--) begin
            if (pend_ff[k]) begin
                topId = IDW'(k);
            end
        end
    end

    // The running handler's priority plays no part: with the mask clear, the lowest-numbered pending source is offered.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqTake_ff <= 1'b0;
            irqId_ff <= '0;
        end else begin
            irqTake_ff <= anyPend && !flags_ff[cfsp_pkg::BIT_I] && !busy_ff && !acc;
            irqId_ff <= topId;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_HALF_CARRY: assert property (@(posedge clk) disable iff (!rst_b)
        aluOnly && alu.isAdd |=> flags_ff[cfsp_pkg::BIT_H] == $past(halfX[cfsp_pkg::BIT_H]))
        else $error("nibble carry flag wrong after add");
    AST_ENTRY_MASKS: assert property (@(posedge clk) disable iff (!rst_b)
        entry |=> flags_ff[cfsp_pkg::BIT_I] && busy_ff)
        else $error("mask not set on handler entry");
    AST_UNMASK: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_UNMASK && !restore |=> !flags_ff[cfsp_pkg::BIT_I])
        else $error("unmask did not clear the mask");
    AST_PEND_HELD: assert property (@(posedge clk) disable iff (!rst_b)
        pend_ff[0] && !(acc && req.cmd == cfsp_pkg::CMD_INT_ENTRY) |=> pend_ff[0])
        else $error("pending request lost");
    AST_RETURN_FROM_HANDLER_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
        restore && kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER |=> !flags_ff[cfsp_pkg::BIT_I] && done_ff)
        else $error("handler return left mask set");
    AST_TAKE: assert property (@(posedge clk) disable iff (!rst_b)
        anyPend && !flags_ff[cfsp_pkg::BIT_I] && !busy_ff && !acc |=> irqTake_ff)
        else $error("unmasked pending request not offered");
    AST_SIGN_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        aluOnly |=> flags_ff[cfsp_pkg::BIT_N] == $past(alu.result[7])
            && flags_ff[cfsp_pkg::BIT_Z] == ($past(alu.result) == 8'h00))
        else $error("sign or zero flag wrong");
    AST_CARRY_SET: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_CARRY_SET && !restore |=> flags_ff[cfsp_pkg::BIT_C])
        else $error("carry not forced high");
    AST_SP_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
        sp_ff[15:8] == cfsp_pkg::SP_HIGH && flags_ff[7:5] == 3'h7)
        else $error("fixed pointer or flag bits changed");
    AST_PUSH_DEC: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == cfsp_pkg::ST_PUSH |=> sp_ff[7:0] == $past(sp_ff[7:0]) - 8'h01)
        else $error("pointer not decremented after push");
    AST_INT_FIVE: assert property (@(posedge clk) disable iff (!rst_b)
        entry |-> ##6 (done_ff && sp_ff[7:0] == $past(sp_ff[7:0], 6) - 8'h05))
        else $error("handler entry did not take five bytes");
    AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_SP_RELOAD |=> sp_ff == cfsp_pkg::SP_RESET)
        else $error("pointer reload wrong");

    AST_MASK_SET: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_MASK_SET |=> flags_ff[cfsp_pkg::BIT_I])
        else $error("mask set did not set the mask");
    AST_CARRY_CLR: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_CARRY_CLR |=> !flags_ff[cfsp_pkg::BIT_C])
        else $error("carry not forced low");
    AST_CARRY_ALU: assert property (@(posedge clk) disable iff (!rst_b)
        aluOnly && (alu.isAdd || alu.updC) && !acc |=> flags_ff[cfsp_pkg::BIT_C] == $past(alu.carry))
        else $error("carry flag did not follow the result");
    AST_POP_INC: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == cfsp_pkg::ST_POPA |=> sp_ff[7:0] == $past(sp_ff[7:0]) + 8'h01)
        else $error("pointer not incremented before pop");
    AST_CALL_TWO: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_CALL |-> ##3 (done_ff && sp_ff[7:0] == $past(sp_ff[7:0], 3) - 8'h02))
        else $error("call did not take two bytes");
    AST_RET_TWO: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_RET |-> ##5 (done_ff && sp_ff[7:0] == $past(sp_ff[7:0], 5) + 8'h02))
        else $error("return did not release two bytes");
    AST_POP_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
        restore && kind_ff == cfsp_pkg::CMD_POP_FLAGS |=> flags_ff == ($past(ramRd) | cfsp_pkg::FLAG_FIXED))
        else $error("flag register not restored from the stack");
    AST_RETURN_FROM_HANDLER_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
        restore && kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER |=> flags_ff
            == (($past(popSh_ff[31:24]) | cfsp_pkg::FLAG_FIXED) & ~(8'h01 << cfsp_pkg::BIT_I)))
        else $error("handler return restored the wrong flags");
    AST_SP_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        acc && req.cmd == cfsp_pkg::CMD_SP_LOAD |=> sp_ff == {cfsp_pkg::SP_HIGH, $past(req.data)})
        else $error("pointer low byte not loaded");
    AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
        flags_ff[cfsp_pkg::BIT_I] |=> !irqTake_ff)
        else $error("request offered while masked");
    AST_PEND_SET: assert property (@(posedge clk) disable iff (!rst_b)
        irqReq[0] |=> pend_ff[0])
        else $error("interrupt request not latched");

    COV_ENTRY: cover property (@(posedge clk) disable iff (!rst_b) entry ##6 done_ff);
    COV_RETURN_FROM_HANDLER: cover property (@(posedge clk) disable iff (!rst_b) restore && kind_ff == cfsp_pkg::CMD_RETURN_FROM_HANDLER);
    COV_TAKE: cover property (@(posedge clk) disable iff (!rst_b) irqTake_ff);
    COV_WRAP: cover property (@(posedge clk) disable iff (!rst_b)
        state_ff == cfsp_pkg::ST_PUSH && sp_ff[7:0] == 8'h00);
    COV_TRAP: cover property (@(posedge clk) disable iff (!rst_b) acc && req.cmd == cfsp_pkg::CMD_TRAP);

endmodule

// *** verif/cfsp_exec_model.sv ***
// Behavioural execution unit facing the flag and stack block.
// Assumes one shared clock; it answers pending interrupts with an entry request.
`timescale 1ns/1ps
module cfsp_exec_model (
    input wire logic clk,
    input wire logic autoIrq,
    input wire logic tbValid,
    input wire cfsp_pkg::cfsp_req_t tbReq,
    input wire logic busy_ff,
    input wire logic done_ff,
    input wire logic irqTake_ff,
    input wire logic [1:0] irqId_ff,
    output logic reqValid,
    output cfsp_pkg::cfsp_req_t req,
    output logic [3:0] entries
);
    // ----------------------------------------------------------------
    // Request arbitration and interrupt answer
    // ----------------------------------------------------------------
    logic pValid;
    cfsp_pkg::cfsp_req_t pReq;
    int n;

    assign reqValid = tbValid | pValid;
    assign req = pValid ? pReq : tbReq;

    // The saved context carries the interrupt index so each return can be told apart.
    initial begin
        pValid = 1'b0;
        pReq = '0;
        entries = 4'h0;
        forever begin
            @(negedge clk);
            if (autoIrq && irqTake_ff === 1'b1 && busy_ff === 1'b0) begin
                pReq.cmd = cfsp_pkg::CMD_INT_ENTRY;
                pReq.data = {6'h00, irqId_ff};
                pReq.pc = {14'h3000, irqId_ff};
                pReq.x = {6'h0c, irqId_ff};
                pReq.acc = {6'h28, irqId_ff};
                pValid = 1'b1;
                @(negedge clk);
                pValid = 1'b0;
                n = 0;
                while (done_ff !== 1'b1 && n < 20) begin
                    @(negedge clk);
                    n++;
                end
                entries = entries + 4'h1;
            end
        end
    end
endmodule

// *** verif/cpu_flags_and_stack_pointer_test.sv ***
// Self-checking bench for the flag register and stack pointer block.
// Assumes the execution model owns the request bus while interrupts are answered.
`timescale 1ns/1ps
module cpu_flags_and_stack_pointer_test;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    typedef struct packed {
        cfsp_pkg::cfsp_cmd_t cmd;
        logic [7:0] data;
        cfsp_pkg::cfsp_alu_t alu;
        logic [7:0] flags;
        logic [15:0] sp;
    } cfsp_row_t;

    logic clk;
    logic rst_b;
    logic tbValid;
    logic autoIrq;
    cfsp_pkg::cfsp_req_t tbReq;
    cfsp_pkg::cfsp_req_t req;
    cfsp_pkg::cfsp_alu_t alu;
    logic [3:0] irqReq;
    logic reqValid;
    logic busy_ff;
    logic done_ff;
    logic [7:0] flags_ff;
    logic [15:0] sp_ff;
    logic [7:0] popData_ff;
    cfsp_pkg::cfsp_ctx_t ctx_ff;
    logic irqTake_ff;
    logic [1:0] irqId_ff;
    logic [3:0] entries;
    cfsp_row_t rows [10];
    int failCount;
    int checked;

    cfsp_flags_stack #(.IRQ_NUM(4)) u_cfsp_flags_stack (.clk(clk), .rst_b(rst_b), .reqValid(reqValid),
        .req(req), .alu(alu), .irqReq(irqReq), .busy_ff(busy_ff), .done_ff(done_ff), .flags_ff(flags_ff),
        .sp_ff(sp_ff), .popData_ff(popData_ff), .ctx_ff(ctx_ff), .irqTake_ff(irqTake_ff), .irqId_ff(irqId_ff));

    cfsp_exec_model u_cfsp_exec_model (.clk(clk), .autoIrq(autoIrq), .tbValid(tbValid), .tbReq(tbReq),
        .busy_ff(busy_ff), .done_ff(done_ff), .irqTake_ff(irqTake_ff), .irqId_ff(irqId_ff),
        .reqValid(reqValid), .req(req), .entries(entries));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (failCount == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic op(input cfsp_pkg::cfsp_cmd_t c, input logic [7:0] d);
        @(negedge clk);
        tbValid = 1'b1;
        tbReq.cmd = c;
        tbReq.data = d;
        @(negedge clk);
        tbValid = 1'b0;
        @(negedge clk);
    endtask

    // Issues a stack sequence and returns how many cycles passed until done.
    task automatic seq(input cfsp_pkg::cfsp_cmd_t c, input logic [7:0] d, output int n);
        @(negedge clk);
        tbValid = 1'b1;
        tbReq.cmd = c;
        tbReq.data = d;
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            tbValid = 1'b0;
            n++;
            if (n == 1) check(busy_ff, 1'b1);
        end while (done_ff !== 1'b1 && n < 20);
        check(busy_ff, 1'b0);
    endtask

    task automatic irqPulse(input logic [3:0] r);
        @(negedge clk);
        irqReq = r;
        @(negedge clk);
        irqReq = 4'h0;
        repeat (6) @(negedge clk);
    endtask

    task automatic waitEntries(input logic [3:0] want);
        int n;
        n = 0;
        while (entries !== want && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(entries, want);
    endtask

    initial begin
        #40000;
        failCount++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        rst_b = 1'b0;
        tbValid = 1'b0;
        autoIrq = 1'b0;
        tbReq = '0;
        alu = '0;
        irqReq = 4'h0;
        failCount = 0;
        checked = 0;
        rows = '{
            '{cfsp_pkg::CMD_CARRY_SET, 8'h00, '0, 8'he9, 16'h01ff},
            '{cfsp_pkg::CMD_CARRY_CLR, 8'h00, '0, 8'he8, 16'h01ff},
            '{cfsp_pkg::CMD_UNMASK, 8'h00, '0, 8'he0, 16'h01ff},
            '{cfsp_pkg::CMD_MASK_SET, 8'h00, '0, 8'he8, 16'h01ff},
            '{cfsp_pkg::CMD_SP_LOAD, 8'h40, '0, 8'he8, 16'h0140},
            '{cfsp_pkg::CMD_SP_RELOAD, 8'h00, '0, 8'he8, 16'h01ff},
            '{cfsp_pkg::CMD_NOP, 8'h00, '{1'b1, 1'b1, 1'b0, 8'h08, 8'h08, 8'h10, 1'b0}, 8'hf8, 16'h01ff},
            '{cfsp_pkg::CMD_NOP, 8'h00, '{1'b1, 1'b1, 1'b0, 8'h80, 8'h80, 8'h00, 1'b1}, 8'heb, 16'h01ff},
            '{cfsp_pkg::CMD_NOP, 8'h00, '{1'b1, 1'b0, 1'b1, 8'h40, 8'h00, 8'h80, 1'b0}, 8'hec, 16'h01ff},
            '{cfsp_pkg::CMD_NOP, 8'h00, '{1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1}, 8'hea, 16'h01ff}
        };
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        check(flags_ff, 8'he8);
        check(sp_ff, 16'h01ff);
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            tbValid = (rows[i].cmd != cfsp_pkg::CMD_NOP);
            tbReq.cmd = rows[i].cmd;
            tbReq.data = rows[i].data;
            alu = rows[i].alu;
            @(negedge clk);
            tbValid = 1'b0;
            alu = '0;
            @(negedge clk);
            check(flags_ff, rows[i].flags);
            check(sp_ff, rows[i].sp);
        end
        op(cfsp_pkg::CMD_SP_LOAD, 8'h00);
        check(sp_ff, 16'h0100);
        seq(cfsp_pkg::CMD_PUSH, 8'h5a, n);
        check(40'(n), 40'd2);
        check(sp_ff, 16'h01ff);
        seq(cfsp_pkg::CMD_POP, 8'h00, n);
        check(40'(n), 40'd3);
        check(popData_ff, 8'h5a);
        check(sp_ff, 16'h0100);
        seq(cfsp_pkg::CMD_PUSH, 8'h00, n);
        seq(cfsp_pkg::CMD_POP_FLAGS, 8'h00, n);
        check(flags_ff, 8'he0);
        op(cfsp_pkg::CMD_CARRY_SET, 8'h00);
        seq(cfsp_pkg::CMD_PUSH_FLAGS, 8'h00, n);
        op(cfsp_pkg::CMD_CARRY_CLR, 8'h00);
        seq(cfsp_pkg::CMD_POP_FLAGS, 8'h00, n);
        check(flags_ff, 8'he1);
        op(cfsp_pkg::CMD_SP_RELOAD, 8'h00);
        op(cfsp_pkg::CMD_MASK_SET, 8'h00);
        tbReq.pc = 16'h1234;
        seq(cfsp_pkg::CMD_CALL, 8'h00, n);
        check(sp_ff, 16'h01fd);
        tbReq.pc = 16'h0000;
        seq(cfsp_pkg::CMD_RET, 8'h00, n);
        check(40'(n), 40'd5);
        check(ctx_ff.pc, 16'h1234);
        check(sp_ff, 16'h01ff);
        autoIrq = 1'b1;
        irqPulse(4'h4);
        check(irqTake_ff, 1'b0);
        check(entries, 4'h0);
        op(cfsp_pkg::CMD_UNMASK, 8'h00);
        waitEntries(4'h1);
        check(sp_ff, 16'h01fa);
        check(flags_ff[3], 1'b1);
        irqPulse(4'h8);
        check(entries, 4'h1);
        op(cfsp_pkg::CMD_UNMASK, 8'h00);
        waitEntries(4'h2);
        check(sp_ff, 16'h01f5);
        autoIrq = 1'b0;
        seq(cfsp_pkg::CMD_RETURN_FROM_HANDLER, 8'h00, n);
        check(40'(n), 40'd11);
        check(ctx_ff, {16'hc003, 8'h33, 8'ha3});
        check(flags_ff[3], 1'b0);
        check(flags_ff, 8'he1);
        check(sp_ff, 16'h01fa);
        seq(cfsp_pkg::CMD_RETURN_FROM_HANDLER, 8'h00, n);
        check(ctx_ff, {16'hc002, 8'h32, 8'ha2});
        check(sp_ff, 16'h01ff);
        op(cfsp_pkg::CMD_MASK_SET, 8'h00);
        seq(cfsp_pkg::CMD_TRAP, 8'h00, n);
        check(40'(n), 40'd6);
        check(flags_ff[3], 1'b1);
        seq(cfsp_pkg::CMD_RETURN_FROM_HANDLER, 8'h00, n);
        check(ctx_ff, 32'h0);
        check(flags_ff, 8'he1);
        check(sp_ff, 16'h01ff);
        @(negedge clk);
        tbValid = 1'b1;
        tbReq.cmd = cfsp_pkg::CMD_CALL;
        repeat (2) @(negedge clk);
        rst_b = 1'b0;
        tbValid = 1'b0;
        @(negedge clk);
        check(sp_ff, 16'h01ff);
        check(flags_ff, 8'he8);
        check(busy_ff, 1'b0);
        rst_b = 1'b1;
        seq(cfsp_pkg::CMD_PUSH, 8'h77, n);
        check(40'(n), 40'd2);
        check(sp_ff, 16'h01fe);
        complete_run();
    end
endmodule
